// ### hdl/tpg_timer.sv
`timescale 1ns/10ps

module tpg_timer
	import tpg_pkg::*;
(
	input  wire logic        i_sys_clk,         // system clock, 200 MHz
	input  wire logic        i_srst,            // synchronous reset, active high
	input  wire logic        i_wb_cyc,          // wishbone cycle
	input  wire logic        i_wb_stb,          // wishbone strobe
	input  wire logic        i_wb_we,           // wishbone write enable
	input  wire logic [7:0]  i_wb_adr,          // wishbone byte address
	input  wire logic [3:0]  i_wb_sel,          // wishbone byte lanes
	input  wire logic [31:0] i_wb_dat,          // wishbone write data
	output logic      [31:0] o_wb_dat,          // wishbone read data
	output logic             o_wb_ack,          // wishbone ack
	input  wire logic        i_capture_input_a, // capture/trigger pin a
	input  wire logic        i_capture_input_b, // capture pin b
	output logic             o_timer_output_pin,// timer output
	output logic             o_match_irq_a,     // match/capture event a
	output logic             o_match_irq_b      // match/capture event b
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// edge detector against an edge select code
	function automatic logic edge_hit(input logic [1:0] sel, input logic prv, input logic cur);
		logic rise;
		logic fall;
		rise = ~prv & cur;
		fall = prv & ~cur;
		unique case (sel)
			EDGE_FALL: edge_hit = fall;
			EDGE_RISE: edge_hit = rise;
			EDGE_BOTH: edge_hit = rise | fall;
			default:   edge_hit = 1'b0; // no edge selected
		endcase
	endfunction

	// opposite-phase edge: only defined for a single-edge select
	function automatic logic [1:0] rev_sel(input logic [1:0] sel);
		unique case (sel)
			EDGE_FALL: rev_sel = EDGE_RISE;
			EDGE_RISE: rev_sel = EDGE_FALL;
			default:   rev_sel = 2'h2; // no opposite edge
		endcase
	endfunction

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		lane_merge = res;
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	tpg_state_t  st_ff;      // registered state
	tpg_state_t  nxt_st;     // next state
	logic        wb_req;     // new bus request this cycle
	logic        wr_en;      // write takes effect
	logic [31:0] wr_word;    // merged write data
	logic        run;        // counter is running
	logic        tick;       // count clock enable from prescaler
	logic        ea_v;       // valid edge on input a
	logic        ea_r;       // reverse edge on input a
	logic        eb_v;       // valid edge on input b
	logic        os_mode;    // one-shot output enabled
	logic        os_trig;    // one-shot trigger
	logic        clr_cnt;    // clear and restart
	logic        m_a;        // counter matches compare a
	logic        m_b;        // counter matches compare b
	logic        cap_a;      // capture into register a
	logic        cap_b;      // capture into register b
	logic        ovf_ev;     // counter wrapped
	logic [15:0] last_cmp;   // later of the two one-shot matches
	logic [31:0] rd_word;    // read mux

	// ****************************************************************
	// combinational next state
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;

		// pin synchronisers: s1 feeds s2 only
		nxt_st.in_a.s1 = i_capture_input_a;
		nxt_st.in_a.s2 = st_ff.in_a.s1;
		nxt_st.in_a.s3 = st_ff.in_a.s2;
		nxt_st.in_b.s1 = i_capture_input_b;
		nxt_st.in_b.s2 = st_ff.in_b.s1;
		nxt_st.in_b.s3 = st_ff.in_b.s2;

		// bus decode, answer one cycle after the request
		wb_req  = i_wb_cyc & i_wb_stb & ~st_ff.ack;
		wr_en   = wb_req & i_wb_we;
		nxt_st.ack = wb_req;

		// prescaler: count clock every 2^sel system clocks
		nxt_st.pdiv = st_ff.pdiv + 3'h1;
		unique case (st_ff.pre[PRE_CS_LO_BIT +: 2])
			2'h0:    tick = 1'b1;
			2'h1:    tick = st_ff.pdiv[0];
			2'h2:    tick = &st_ff.pdiv[1:0];
			2'h3:    tick = &st_ff.pdiv;
		endcase

		run = (st_ff.mode != MODE_STOP);

		// edge detection on synchronised pins
		ea_v = run & edge_hit(st_ff.pre[PRE_ES_A_LO_BIT +: 2], st_ff.in_a.s3, st_ff.in_a.s2);
		ea_r = run & edge_hit(rev_sel(st_ff.pre[PRE_ES_A_LO_BIT +: 2]), st_ff.in_a.s3, st_ff.in_a.s2);
		eb_v = run & edge_hit(st_ff.pre[PRE_ES_B_LO_BIT +: 2], st_ff.in_b.s3, st_ff.in_b.s2);

		// one-shot only in free or edge-clear mode with enable set
		os_mode = st_ff.oc[OC_OSPE_BIT] & (st_ff.mode == MODE_FREE | st_ff.mode == MODE_EDGE);
		os_trig = os_mode & ((wr_en & i_wb_adr == ADDR_OUT_CTRL & i_wb_sel[0]
			& i_wb_dat[OC_OSPT_BIT]) | ea_v);
		clr_cnt = (st_ff.mode == MODE_EDGE & ea_v) | os_trig;

		// compare matches on the count clock, only for compare registers
		m_a = run & tick & ~clr_cnt & ~st_ff.ccc[CCC_A_CAP_BIT] & (st_ff.cnt == st_ff.cmp_a);
		m_b = run & tick & ~clr_cnt & ~st_ff.ccc[CCC_B_CAP_BIT] & (st_ff.cnt == st_ff.cmp_b);

		// capture sources
		cap_a = st_ff.ccc[CCC_A_CAP_BIT] & (st_ff.ccc[CCC_A_SRC_BIT] ? ea_r : eb_v);
		cap_b = st_ff.ccc[CCC_B_CAP_BIT] & ea_v;

		// counter
		ovf_ev = 1'b0;
		if (!run) begin
			nxt_st.cnt = CNT_ZERO;
		end else if (clr_cnt) begin
			nxt_st.cnt = CNT_ZERO;
		end else if (tick) begin
			if (st_ff.mode == MODE_PPG & m_a) begin
				nxt_st.cnt = CNT_ZERO;
			end else begin
				nxt_st.cnt = st_ff.cnt + 16'h0001;
				ovf_ev = (st_ff.cnt == CNT_MAX);
			end
		end

		// interrupts: matches and captures, registered one cycle later
		nxt_st.irq_a = m_a | cap_a;
		nxt_st.irq_b = m_b | cap_b;

		// timer output level
		last_cmp = (st_ff.cmp_a > st_ff.cmp_b) ? st_ff.cmp_a : st_ff.cmp_b;
		if (!run) begin
			// level set/clear only while stopped
			if (st_ff.oc[OC_LVS_BIT] & ~st_ff.oc[OC_LVR_BIT]) begin
				nxt_st.lvl = 1'b1;
			end else if (st_ff.oc[OC_LVR_BIT] & ~st_ff.oc[OC_LVS_BIT]) begin
				nxt_st.lvl = 1'b0;
			end
			nxt_st.armed = 1'b0;
		end else if (st_ff.mode == MODE_PPG) begin
			// high from clear to match b, low to match a
			if (m_a) begin
				nxt_st.lvl = 1'b1;
			end else if (m_b) begin
				nxt_st.lvl = 1'b0;
			end
		end else if (os_mode) begin
			if (os_trig) begin
				nxt_st.lvl   = 1'b0;
				nxt_st.armed = 1'b1;
			end else if (st_ff.armed) begin
				// each match inverts once, pulse ends at the later one
				nxt_st.lvl = st_ff.lvl ^ m_a ^ m_b;
				if ((m_a & st_ff.cnt == last_cmp) | (m_b & st_ff.cnt == last_cmp)) begin
					nxt_st.armed = 1'b0;
				end
			end
		end else begin
			// free-running or edge-clear compare without one-shot: invert when enabled
			nxt_st.lvl = st_ff.lvl ^ (m_a & st_ff.oc[OC_INV_A_BIT]) ^ (m_b & st_ff.oc[OC_INV_B_BIT]);
		end

		// register writes
		wr_word = WORD_ZERO;
		if (wr_en) begin
			unique case (i_wb_adr)
				ADDR_CMP_CAP_A: begin
					wr_word = lane_merge({16'h0000, st_ff.cmp_a}, i_wb_dat, i_wb_sel);
					nxt_st.cmp_a = wr_word[15:0];
				end
				ADDR_CMP_CAP_B: begin
					wr_word = lane_merge({16'h0000, st_ff.cmp_b}, i_wb_dat, i_wb_sel);
					nxt_st.cmp_b = wr_word[15:0];
				end
				ADDR_MODE_CTRL: begin
					if (i_wb_sel[0]) begin
						nxt_st.mode = tpg_mode_t'(i_wb_dat[MODE_RUN_LO_BIT +: 2]);
						nxt_st.ovf  = i_wb_dat[MODE_OVF_BIT];
					end
				end
				ADDR_CAP_CMP_CTRL: begin
					if (i_wb_sel[0]) begin
						nxt_st.ccc = i_wb_dat[2:0];
					end
				end
				ADDR_OUT_CTRL: begin
					if (i_wb_sel[0]) begin
						nxt_st.oc = i_wb_dat[5:0];
					end
				end
				ADDR_PRESCALER: begin
					if (i_wb_sel[0]) begin
						nxt_st.pre = i_wb_dat[7:0];
					end
				end
				default: begin
					// counter and unmapped: write ignored
				end
			endcase
		end

		// captures win over a software write in the same cycle
		if (cap_a) begin
			nxt_st.cmp_a = st_ff.cnt;
		end
		if (cap_b) begin
			nxt_st.cmp_b = st_ff.cnt;
		end
		// overflow set wins over clear
		if (ovf_ev) begin
			nxt_st.ovf = 1'b1;
		end

		// read data
		unique case (i_wb_adr)
			ADDR_UP_COUNTER:   rd_word = {16'h0000, st_ff.cnt};
			ADDR_CMP_CAP_A:    rd_word = {16'h0000, st_ff.cmp_a};
			ADDR_CMP_CAP_B:    rd_word = {16'h0000, st_ff.cmp_b};
			ADDR_MODE_CTRL:    rd_word = {28'h0000000, st_ff.mode, 1'b0, st_ff.ovf};
			ADDR_CAP_CMP_CTRL: rd_word = {29'h00000000, st_ff.ccc};
			ADDR_OUT_CTRL:     rd_word = {26'h0000000, st_ff.oc};
			ADDR_PRESCALER:    rd_word = {24'h000000, st_ff.pre};
			default:           rd_word = WORD_ZERO;
		endcase
		nxt_st.rdat = (wb_req & ~i_wb_we) ? rd_word : WORD_ZERO;
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			st_ff <= '{
				cnt: CNT_ZERO, cmp_a: CNT_ZERO, cmp_b: CNT_ZERO, mode: MODE_STOP,
				ovf: 1'b0, ccc: 3'h0, oc: 6'h00, pre: 8'h00, pdiv: PDIV_RESET,
				lvl: 1'b0, armed: 1'b0, irq_a: 1'b0, irq_b: 1'b0, ack: 1'b0,
				rdat: WORD_ZERO, in_a: '{s1: 1'b0, s2: 1'b0, s3: 1'b0},
				in_b: '{s1: 1'b0, s2: 1'b0, s3: 1'b0}
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign o_wb_ack           = st_ff.ack;
	assign o_wb_dat           = st_ff.rdat;
	assign o_timer_output_pin = st_ff.lvl & st_ff.oc[OC_TOE_BIT];
	assign o_match_irq_a      = st_ff.irq_a;
	assign o_match_irq_b      = st_ff.irq_b;

endmodule // tpg_timer

// ### hdl/tpg_pkg.sv
package tpg_pkg;

	// ****************************************************************
	// register map, byte addresses on the wishbone port
	// ****************************************************************
	localparam logic [7:0] ADDR_UP_COUNTER   = 8'h00; // counter, read only
	localparam logic [7:0] ADDR_CMP_CAP_A    = 8'h04; // compare/capture a
	localparam logic [7:0] ADDR_CMP_CAP_B    = 8'h08; // compare/capture b
	localparam logic [7:0] ADDR_MODE_CTRL    = 8'h0C; // run mode and overflow flag
	localparam logic [7:0] ADDR_CAP_CMP_CTRL = 8'h10; // capture/compare selection
	localparam logic [7:0] ADDR_OUT_CTRL     = 8'h14; // output control
	localparam logic [7:0] ADDR_PRESCALER    = 8'h18; // prescaler and edge select

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int MODE_OVF_BIT    = 0; // overflow flag
	localparam int MODE_RUN_LO_BIT = 2; // run_mode_lo
	localparam int MODE_RUN_HI_BIT = 3; // run_mode_hi
	localparam int CCC_A_CAP_BIT   = 0; // register a captures
	localparam int CCC_A_SRC_BIT   = 1; // a capture source: 1 reverse edge of input a
	localparam int CCC_B_CAP_BIT   = 2; // register b captures
	localparam int OC_TOE_BIT      = 0; // output_enable
	localparam int OC_INV_A_BIT    = 1; // invert_on_match_a
	localparam int OC_LVR_BIT      = 2; // output_level_clear
	localparam int OC_LVS_BIT      = 3; // output_level_set
	localparam int OC_INV_B_BIT    = 4; // invert_on_match_b
	localparam int OC_OSPE_BIT     = 5; // oneshot_enable
	localparam int OC_OSPT_BIT     = 6; // oneshot_soft_trigger, write only
	localparam int PRE_CS_LO_BIT   = 0; // clock_select_lo
	localparam int PRE_ES_A_LO_BIT = 4; // edge_sel_a_lo
	localparam int PRE_ES_B_LO_BIT = 6; // edge_sel_b_lo

	// ****************************************************************
	// reset values and constants
	// ****************************************************************
	localparam logic [15:0] CNT_MAX     = 16'hFFFF; // wrap point
	localparam logic [15:0] CNT_ZERO    = 16'h0000; // cleared count
	localparam logic [1:0]  EDGE_FALL   = 2'h0;     // edge select: falling
	localparam logic [1:0]  EDGE_RISE   = 2'h1;     // edge select: rising
	localparam logic [1:0]  EDGE_BOTH   = 2'h3;     // edge select: both
	localparam logic [2:0]  PDIV_RESET  = 3'h0;     // prescaler counter reset
	localparam logic [31:0] WORD_ZERO   = 32'h0000_0000; // reset for words

	// run modes
	typedef enum logic [1:0] {
		MODE_STOP = 2'b00,
		MODE_FREE = 2'b01,
		MODE_EDGE = 2'b10,
		MODE_PPG  = 2'b11
	} tpg_mode_t;

	// synchronised pin, two stages and a history stage
	typedef struct packed {
		logic s1; // first stage, read only by s2
		logic s2; // second stage
		logic s3; // history for edge detection
	} tpg_sync_t;

	// whole state of the block
	typedef struct packed {
		logic [15:0] cnt;    // up_counter
		logic [15:0] cmp_a;  // compare_capture_a
		logic [15:0] cmp_b;  // compare_capture_b
		tpg_mode_t   mode;   // run mode
		logic        ovf;    // overflow_flag
		logic [2:0]  ccc;    // capture_compare_ctrl
		logic [5:0]  oc;     // output_control_reg bits 5..0
		logic [7:0]  pre;    // prescaler_reg
		logic [2:0]  pdiv;   // prescaler counter
		logic        lvl;    // timer output level
		logic        armed;  // one-shot pulse in progress
		logic        irq_a;  // match_irq_a pulse
		logic        irq_b;  // match_irq_b pulse
		logic        ack;    // wishbone ack
		logic [31:0] rdat;   // wishbone read data
		tpg_sync_t   in_a;   // capture_input_a sync
		tpg_sync_t   in_b;   // capture_input_b sync
	} tpg_state_t;

endpackage

// ### verification/tpg_timer_asserts.sv
`timescale 1ns/10ps
// ****************
// bus and timer checker
// ****************
module tpg_timer_asserts
	import tpg_pkg::*;
(
	input  wire logic        i_sys_clk,          // system clock
	input  wire logic        i_srst,             // synchronous reset
	input  wire logic        i_wb_cyc,           // bus cycle
	input  wire logic        i_wb_stb,           // bus strobe
	input  wire logic        i_wb_we,            // bus write
	input  wire logic [7:0]  i_wb_adr,           // bus address
	input  wire logic [3:0]  i_wb_sel,           // bus lanes
	input  wire logic [31:0] i_wb_dat,           // write data
	input  wire logic [31:0] o_wb_dat,           // read data
	input  wire logic        o_wb_ack,           // bus ack
	input  wire logic        i_capture_input_a,  // pin a
	input  wire logic        i_capture_input_b,  // pin b
	input  wire logic        o_timer_output_pin, // timer output
	input  wire logic        o_match_irq_a,      // event a
	input  wire logic        o_match_irq_b       // event b
);
	logic        wr_hit;  // write taken this cycle
	logic [1:0]  mode_ff; // last written run mode
	logic        oe_ff;   // last written output enable
	logic        seen_ff; // one ppg period already passed
	logic [7:0]  adr_ff;  // address of the open request
	logic [15:0] cmpa_ff; // last written compare a
	logic [15:0] cmpb_ff; // last written compare b
	logic [15:0] gap_ff;  // clocks since the last event a
	assign wr_hit = o_wb_ack && i_wb_we && i_wb_sel[0];
	// mirrors of what software wrote, so periods can be predicted
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			mode_ff <= 2'h0;
			oe_ff <= 1'b0;
			seen_ff <= 1'b0;
		end else begin
			if (i_wb_cyc && i_wb_stb && !o_wb_ack) adr_ff <= i_wb_adr;
			if (wr_hit && i_wb_adr == ADDR_MODE_CTRL) mode_ff <= i_wb_dat[3:2];
			if (wr_hit && i_wb_adr == ADDR_OUT_CTRL) oe_ff <= i_wb_dat[OC_TOE_BIT];
			if (wr_hit && i_wb_adr == ADDR_CMP_CAP_A) cmpa_ff <= i_wb_dat[15:0];
			if (wr_hit && i_wb_adr == ADDR_CMP_CAP_B) cmpb_ff <= i_wb_dat[15:0];
			gap_ff <= o_match_irq_a ? CNT_ZERO : gap_ff + 16'h1;
			// any write may change the period, so start over
			seen_ff <= !wr_hit && (seen_ff || o_match_irq_a);
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence s_answer;
		o_wb_ack ##1 !o_wb_ack;
	endsequence
	a_ack_timing: assert property (s_req |=> s_answer)
		else $error("ack not a single cycle after request");
	a_ack_cause: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without request");
	a_rdat_idle: assert property (!o_wb_ack |-> o_wb_dat == WORD_ZERO)
		else $error("read data outside ack");
	a_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0)
		else $error("upper read bits set");
	a_stop_count: assert property (o_wb_ack && !i_wb_we && adr_ff == ADDR_UP_COUNTER && mode_ff == MODE_STOP |-> o_wb_dat == WORD_ZERO)
		else $error("counter not zero while stopped");
	a_pin_gate: assert property (!oe_ff && !o_wb_ack |-> !o_timer_output_pin)
		else $error("output driven while disabled");
	a_ppg_period: assert property (o_match_irq_a && seen_ff && mode_ff == MODE_PPG |-> gap_ff == cmpa_ff)
		else $error("ppg period wrong");
	a_ppg_mid: assert property (o_match_irq_b && seen_ff && mode_ff == MODE_PPG |-> gap_ff == cmpb_ff)
		else $error("ppg compare b event misplaced");
endmodule // tpg_timer_asserts

bind tpg_timer tpg_timer_asserts i_tpg_timer_asserts (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
	.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_capture_input_a(i_capture_input_a),
	.i_capture_input_b(i_capture_input_b), .o_timer_output_pin(o_timer_output_pin),
	.o_match_irq_a(o_match_irq_a), .o_match_irq_b(o_match_irq_b));

// ### verification/tpg_pins.sv
`timescale 1ns/10ps
// ****************
// external pulse source on the capture pins
// ****************
module tpg_pins (
	input  wire logic        i_sys_clk, // system clock
	input  wire logic        i_go,      // start one waveform
	input  wire logic [15:0] i_hi,      // high time in clocks
	input  wire logic [15:0] i_lo,      // low time in clocks
	input  wire logic [15:0] i_dly,     // lag of pin b behind pin a
	output logic             o_pin_a,   // drives capture input a
	output logic             o_pin_b    // drives capture input b
);
	int t = -1; // clocks since start, -1 when idle
	// two high phases separated by one low phase
	function automatic logic wave(input int x);
		return (x >= 0) && ((x < i_hi) || (x >= i_hi + i_lo && x < 2 * i_hi + i_lo));
	endfunction
	// time base runs only inside a waveform
	always @(posedge i_sys_clk) begin
		if (i_go) t <= 0;
		else if (t >= 0 && t < 2 * (i_hi + i_lo) + i_dly) t <= t + 1;
		else t <= -1;
	end
	assign o_pin_a = wave(t);
	assign o_pin_b = wave(t >= 0 ? t - i_dly : -1);
endmodule // tpg_pins

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench
	import tpg_pkg::*;
;
	logic        clk = 0;    // system clock
	logic        srst = 1;   // reset
	logic        cyc = 0;    // bus cycle
	logic        stb = 0;    // bus strobe
	logic        we = 0;     // bus write
	logic [7:0]  adr = 0;    // bus address
	logic [3:0]  sel = 0;    // bus lanes
	logic [31:0] dat = 0;    // write data
	logic [31:0] rdat;       // read data
	logic        ack;        // bus ack
	logic        pa;         // capture pin a
	logic        pb;         // capture pin b
	logic        pin;        // timer output
	logic        ia;         // event a
	logic        ib;         // event b
	logic        go = 0;     // partner start
	logic [15:0] hi = 16'h7; // partner high time
	logic [15:0] lo = 16'hC; // partner low time
	logic [15:0] dly = 16'h5; // partner pin b lag
	logic [31:0] qa;         // capture a read back
	logic [31:0] qb;         // capture b read back
	int fails = 0;
	int checks_done = 0;
	int tick = 0;
	int n_ia = 0;
	int n_ib = 0;
	int n_hi = 0;
	int b0, b1, b2;
	tpg_timer i_tpg_timer (.i_sys_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_capture_input_a(pa), .i_capture_input_b(pb), .o_timer_output_pin(pin),
		.o_match_irq_a(ia), .o_match_irq_b(ib));
	tpg_pins i_tpg_pins (.i_sys_clk(clk), .i_go(go), .i_hi(hi), .i_lo(lo), .i_dly(dly), .o_pin_a(pa), .o_pin_b(pb));
	always #2.5 clk = ~clk;
	// event and level counters, sampled mid cycle; also the hang limit
	always @(negedge clk) begin
		n_ia += (ia === 1'b1);
		n_ib += (ib === 1'b1);
		n_hi += (pin === 1'b1);
		tick++;
		if (tick == 90000) begin
			fails++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected %0t got %h want %h", $time, got, exp);
			fails++;
		end
	endtask
	// one classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
		if (ack !== 1'b1) begin
			$display("unexpected %0t no ack from the bus", $time);
			fails++;
		end
		q = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic snap();
		b0 = n_hi;
		b1 = n_ia;
		b2 = n_ib;
	endtask
	task automatic deltas(input int h, input int a, input int b);
		chk(32'(n_hi - b0), 32'(h));
		chk(32'(n_ia - b1), 32'(a));
		chk(32'(n_ib - b2), 32'(b));
	endtask
	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (8) @(posedge clk);
		srst <= 0;
		for (int a = 0; a < 8; a++) rd(8'(a * 4), 32'h0);
		wr(ADDR_UP_COUNTER, 32'h1234);
		rd(ADDR_UP_COUNTER, 32'h0);
		wr(ADDR_CMP_CAP_A, 32'h9);
		wr(ADDR_CMP_CAP_B, 32'h3);
		rd(ADDR_CMP_CAP_A, 32'h9);
		wr(ADDR_OUT_CTRL, 32'h13);
		wr(ADDR_MODE_CTRL, 32'hC);
		repeat (200) begin
			@(posedge clk);
			if (ia === 1'b1) break;
		end
		snap();
		repeat (50) @(posedge clk);
		deltas(20, 5, 5);
		wr(ADDR_MODE_CTRL, 32'h0);
		rd(ADDR_UP_COUNTER, 32'h0);
		wr(ADDR_OUT_CTRL, 32'h4);
		wr(ADDR_CMP_CAP_A, 32'h14);
		wr(ADDR_CMP_CAP_B, 32'h1E);
		snap();
		wr(ADDR_OUT_CTRL, 32'h73);
		repeat (60) @(posedge clk);
		deltas(0, 0, 0);
		wr(ADDR_OUT_CTRL, 32'h33);
		wr(ADDR_MODE_CTRL, 32'h4);
		snap();
		wr(ADDR_OUT_CTRL, 32'h73);
		repeat (60) @(posedge clk);
		deltas(10, 1, 1);
		wr(ADDR_MODE_CTRL, 32'h0);
		wr(ADDR_OUT_CTRL, 32'h0);
		wr(ADDR_PRESCALER, 32'h50);
		// two-input, single-input and clear-on-edge measurement
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_CAP_CMP_CTRL, k ? 32'h7 : 32'h5);
			wr(ADDR_MODE_CTRL, k == 2 ? 32'h8 : 32'h4);
			snap();
			@(posedge clk);
			go <= 1;
			@(posedge clk);
			go <= 0;
			repeat (80) @(posedge clk);
			wb(1'b0, ADDR_CMP_CAP_A, 32'h0, qa);
			wb(1'b0, ADDR_CMP_CAP_B, 32'h0, qb);
			if (k < 2) chk(32'(16'(qa - qb)), k ? 32'h7 : 32'h5);
			else begin
				// counter reads zero the clock after the clearing edge
				chk(qa, 32'h6);
				chk(qb, 32'h12);
			end
			deltas(0, 2, 2);
			wr(ADDR_MODE_CTRL, 32'h0);
		end
		wr(ADDR_MODE_CTRL, 32'h4);
		rd(ADDR_MODE_CTRL, 32'h4);
		repeat (65600) @(posedge clk);
		rd(ADDR_MODE_CTRL, 32'h5);
		wr(ADDR_MODE_CTRL, 32'h4);
		rd(ADDR_MODE_CTRL, 32'h4);
		results();
	end
endmodule // testbench
